//--- hw/sifs_map.svh
`ifndef SIFS_MAP_SVH
`define SIFS_MAP_SVH

// ------------------------------------------------------------
// structure
// ------------------------------------------------------------
`define SIFS_NUM_GRP        2
`define SIFS_SPR_PER_GRP    2
`define SIFS_NUM_SPR        4
`define SIFS_FIFO_DEPTH     8

// ------------------------------------------------------------
// register byte addresses and fields
// ------------------------------------------------------------
`define SIFS_ADDR_CTRL      8'h00
`define SIFS_ADDR_STAT      8'h04
`define SIFS_ADDR_GRP0      8'h08
`define SIFS_ADDR_SPR0      8'h10
`define SIFS_ADDR_REQCNT    8'h20
`define SIFS_CTRL_EN_BIT    0
`define SIFS_GRP_HDR_LSB    0
`define SIFS_GRP_PAY_LSB    8
`define SIFS_SPR_TYPE_LSB   0
`define SIFS_SPR_SENS_BIT   2
`define SIFS_SPR_EN_BIT     3
`define SIFS_STAT_OVR_BIT   0
`define SIFS_STAT_HAZ_LSB   4
`define SIFS_STAT_FETCH_LSB 8
`define SIFS_STAT_LVL_LSB   12
`define SIFS_LEAD_RST       8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define SIFS_CLK_PS         10000
`define SIFS_ITER_PS        1041667
`define SIFS_ITER_CYCLES    (`SIFS_ITER_PS / `SIFS_CLK_PS)
`define SIFS_SLOT_ITERS     1280
`define SIFS_FRAME_ITERS    9600
`define SIFS_SUBFRAME_ITERS 1920
`define SIFS_CHUNK_ITERS    16
`define SIFS_HAZ_DIFF_A     8'h08
`define SIFS_HAZ_DIFF_B     8'h10

`endif

//--- hw/sifs_pkg.sv
package sifs_pkg;

  // period kind of a spreader; static channels never fetch
  typedef enum logic [1:0] {
    CH_STATIC   = 2'h0,
    CH_SLOT     = 2'h1,
    CH_FRAME    = 2'h2,
    CH_SUBFRAME = 2'h3
  } sifs_chan_e;

  typedef struct packed {
    logic [1:0] spreader;
    logic       isHeader;
    logic [7:0] chunk;
  } sifs_fetch_s;

  typedef struct packed {
    logic [7:0] hdrLead;
    logic [7:0] payLead;
  } sifs_lead_s;

  typedef struct packed {
    logic       enable;
    logic       sensitive;
    sifs_chan_e chanType;
  } sifs_spr_s;

endpackage : sifs_pkg

//--- hw/sifs_fifo.sv
`timescale 1ns/1ps
module sifs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  input  wire logic                       inValid,
  output logic                            inReady,
  input  wire logic [WIDTH-1:0]           inData,
  output logic                            outValid,
  input  wire logic                       outReady,
  output logic      [WIDTH-1:0]           outData,
  output logic      [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0]         mem_q [DEPTH];
  logic [AW-1:0]            wrPtr_q;
  logic [AW-1:0]            rdPtr_q;
  logic [$clog2(DEPTH+1)-1:0] cnt_q;
  logic                     push;
  logic                     pop;

  // honest flags straight from the count
  assign inReady  = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
  assign outValid = (cnt_q != '0);
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;
  assign outData  = mem_q[rdPtr_q];
  assign level    = cnt_q;

  // storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // pointers wrap since depth is a power of two
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop)  rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : sifs_fifo

//--- hw/sifs_tick.sv
`timescale 1ns/1ps
module sifs_tick #(
  parameter int DIV = 104
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic run,
  output logic      tick
);
  logic [15:0] cnt_q;

  // one-cycle pulse per 4-chip iteration
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule : sifs_tick

//--- hw/sifs_scheduler.sv
// How it works
// - only spreaders set to a periodic channel type fetch; static ones never do
// - each period's input is one header then payload; slot, frame or sub-frame
// - payload goes in 64-bit chunks: first before boundary, rest through period
// - header request goes out header-lead 4-chip iterations before boundary
// - first chunk request goes out payload-lead iterations before boundary
// - one header lead and one payload lead per spreader group, shared
// - sensitive channels whose leads differ by 8 or 16 are flagged only; the schedule is unchanged
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "sifs_map.svh"
module sifs_scheduler
  import sifs_pkg::*;
#(
  parameter int SLOT_ITERS     = `SIFS_SLOT_ITERS,
  parameter int FRAME_ITERS    = `SIFS_FRAME_ITERS,
  parameter int SUBFRAME_ITERS = `SIFS_SUBFRAME_ITERS,
  parameter int ITER_CYCLES    = `SIFS_ITER_CYCLES
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic                          fetchValid,
  input  wire logic                     fetchReady,
  output sifs_fetch_s                   fetchReq,
  output logic      [`SIFS_NUM_SPR-1:0] periodStart
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic                     ctrlEn_q;
  sifs_lead_s               lead_q [`SIFS_NUM_GRP];
  sifs_spr_s                spr_q  [`SIFS_NUM_SPR];
  logic                     ovr_q;
  logic [15:0]              reqCnt_q;
  logic [31:0]              prdata_q;
  logic                     wrEn;
  logic                     setup;
  logic                     hit;
  logic [31:0]              rdVal;
  logic                     tick;
  logic [`SIFS_NUM_SPR-1:0] hdrPendV;
  logic [`SIFS_NUM_SPR-1:0] payPendV;
  logic [`SIFS_NUM_SPR-1:0] hazV;
  logic [`SIFS_NUM_SPR-1:0] fetchV;
  logic [`SIFS_NUM_SPR-1:0] ovrV;
  logic [`SIFS_NUM_SPR-1:0] grantHdr;
  logic [`SIFS_NUM_SPR-1:0] grantPay;
  logic [7:0]               payIdxV [`SIFS_NUM_SPR];
  sifs_fetch_s              pushData;
  logic                     pushValid;
  logic                     pushReady;
  logic [3:0]               fifoLevel;
  logic [1:0]               pick;
  logic                     pickHdr;

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  assign pready  = 1'b1;
  assign setup   = psel & ~penable;
  assign wrEn    = psel & penable & pwrite;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_q;

  // decode and read mux; unmapped reads give zero
  always_comb begin
    hit   = 1'b1;
    rdVal = 32'h0000_0000;
    unique case (paddr)
      `SIFS_ADDR_CTRL: rdVal[`SIFS_CTRL_EN_BIT] = ctrlEn_q;
      `SIFS_ADDR_STAT: begin
        rdVal[`SIFS_STAT_OVR_BIT] = ovr_q;
        rdVal[`SIFS_STAT_HAZ_LSB +: 4] = hazV;
        rdVal[`SIFS_STAT_FETCH_LSB +: 4] = fetchV;
        rdVal[`SIFS_STAT_LVL_LSB +: 4] = fifoLevel;
      end
      `SIFS_ADDR_GRP0, `SIFS_ADDR_GRP0 + 8'h04: begin
        rdVal[`SIFS_GRP_HDR_LSB +: 8] = lead_q[paddr[2]].hdrLead;
        rdVal[`SIFS_GRP_PAY_LSB +: 8] = lead_q[paddr[2]].payLead;
      end
      `SIFS_ADDR_SPR0, `SIFS_ADDR_SPR0 + 8'h04,
      `SIFS_ADDR_SPR0 + 8'h08, `SIFS_ADDR_SPR0 + 8'h0C: begin
        rdVal[`SIFS_SPR_TYPE_LSB +: 2] = spr_q[paddr[3:2]].chanType;
        rdVal[`SIFS_SPR_SENS_BIT] = spr_q[paddr[3:2]].sensitive;
        rdVal[`SIFS_SPR_EN_BIT] = spr_q[paddr[3:2]].enable;
      end
      `SIFS_ADDR_REQCNT: rdVal[15:0] = reqCnt_q;
      default: hit = 1'b0;
    endcase
  end

  // read data captured in the setup phase so it is a flop output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_q <= rdVal;
    end
  end

  // control and per-group lead settings
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrlEn_q <= 1'b0;
      for (int g = 0; g < `SIFS_NUM_GRP; g++) begin
        lead_q[g] <= '{hdrLead: `SIFS_LEAD_RST, payLead: `SIFS_LEAD_RST};
      end
    end else if (wrEn) begin
      if (paddr == `SIFS_ADDR_CTRL) ctrlEn_q <= pwdata[`SIFS_CTRL_EN_BIT];
      if (paddr == `SIFS_ADDR_GRP0 || paddr == `SIFS_ADDR_GRP0 + 8'h04) begin
        lead_q[paddr[2]].hdrLead <= pwdata[`SIFS_GRP_HDR_LSB +: 8];
        lead_q[paddr[2]].payLead <= pwdata[`SIFS_GRP_PAY_LSB +: 8];
      end
    end
  end

  // spreader setup registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int s = 0; s < `SIFS_NUM_SPR; s++) begin
        spr_q[s] <= '{enable: 1'b0, sensitive: 1'b0, chanType: CH_STATIC};
      end
    end else if (wrEn && paddr[7:4] == 4'(`SIFS_ADDR_SPR0 >> 4) && paddr[1:0] == 2'h0) begin
      spr_q[paddr[3:2]].chanType  <= sifs_chan_e'(pwdata[`SIFS_SPR_TYPE_LSB +: 2]);
      spr_q[paddr[3:2]].sensitive <= pwdata[`SIFS_SPR_SENS_BIT];
      spr_q[paddr[3:2]].enable    <= pwdata[`SIFS_SPR_EN_BIT];
    end
  end

  // overrun flag: write one to clear, a new overrun in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ovr_q <= 1'b0;
    end else if (|ovrV) begin
      ovr_q <= 1'b1;
    end else if (wrEn && paddr == `SIFS_ADDR_STAT && pwdata[`SIFS_STAT_OVR_BIT]) begin
      ovr_q <= 1'b0;
    end
  end

  // count of requests accepted into the request fifo toward the memory side
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reqCnt_q <= 16'h0000;
    end else if (pushValid && pushReady) begin
      reqCnt_q <= reqCnt_q + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // iteration timebase
  // ------------------------------------------------------------
  sifs_tick #(
    .DIV (ITER_CYCLES)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (ctrlEn_q),
    .tick    (tick)
  );

  // period length in iterations for each channel kind
  function automatic logic [13:0] periodOf(input sifs_chan_e t);
    unique case (t)
      CH_SLOT:     periodOf = 14'(SLOT_ITERS);
      CH_FRAME:    periodOf = 14'(FRAME_ITERS);
      CH_SUBFRAME: periodOf = 14'(SUBFRAME_ITERS);
      CH_STATIC:   periodOf = 14'h0001;
    endcase
  endfunction : periodOf

  // ------------------------------------------------------------
  // per-spreader schedulers
  // ------------------------------------------------------------
  for (genvar s = 0; s < `SIFS_NUM_SPR; s++) begin : g_spr
    localparam int G = s / `SIFS_SPR_PER_GRP;
    logic [13:0] pos_q;
    logic [13:0] nextPos;
    logic [13:0] period;
    logic [7:0]  chunk_q;
    logic [7:0]  tmr_q;
    logic [7:0]  diff;
    logic        active_q;
    logic        inPeriod_q;
    logic        hdrPend_q;
    logic        payPend_q;
    logic [7:0]  payIdx_q;
    logic        hdrEvt;
    logic        firstEvt;
    logic        chunkEvt;
    logic        bndEvt;
    logic        fetching;
    logic        bnd_q;

    assign fetching = ctrlEn_q & spr_q[s].enable & (spr_q[s].chanType != CH_STATIC);
    assign period   = periodOf(spr_q[s].chanType);
    assign nextPos  = (pos_q == 14'h0000) ? period - 14'h0001 : pos_q - 14'h0001;
    assign hdrEvt   = active_q & tick & (nextPos == {6'h00, lead_q[G].hdrLead});
    assign firstEvt = active_q & tick & (nextPos == {6'h00, lead_q[G].payLead});
    assign bndEvt   = active_q & tick & (nextPos == 14'h0000);
    // later chunks stop before the next period's first one, so they never collide
    assign chunkEvt = inPeriod_q & tick & ~bndEvt
                    & (tmr_q == 8'(`SIFS_CHUNK_ITERS - 1))
                    & (nextPos > {6'h00, lead_q[G].payLead});

    // position counts down iterations to the next boundary
    always_ff @(posedge clk_sys) begin
      if (rst || !fetching) begin
        active_q <= 1'b0;
        pos_q    <= 14'h0000;
      end else if (!active_q) begin
        active_q <= 1'b1;
        pos_q    <= period - 14'h0001;
      end else if (tick) begin
        pos_q <= nextPos;
      end
    end

    // chunk pacing through the period
    always_ff @(posedge clk_sys) begin
      if (rst || !fetching) begin
        inPeriod_q <= 1'b0;
        tmr_q      <= 8'h00;
        chunk_q    <= 8'h00;
      end else begin
        if (bndEvt) begin
          inPeriod_q <= 1'b1;
          tmr_q      <= 8'h00;
        end else if (firstEvt) begin
          inPeriod_q <= 1'b0;
        end else if (inPeriod_q && tick) begin
          tmr_q <= (tmr_q == 8'(`SIFS_CHUNK_ITERS - 1)) ? 8'h00 : tmr_q + 8'h01;
        end
        if (firstEvt) chunk_q <= 8'h00;
        else if (chunkEvt) chunk_q <= chunk_q + 8'h01;
      end
    end

    // pending requests wait for the arbiter; header of a period before its payload
    always_ff @(posedge clk_sys) begin
      if (rst || !fetching) begin
        hdrPend_q <= 1'b0;
        payPend_q <= 1'b0;
        payIdx_q  <= 8'h00;
      end else begin
        if (hdrEvt) hdrPend_q <= 1'b1;
        else if (grantHdr[s]) hdrPend_q <= 1'b0;
        if (firstEvt) begin
          payPend_q <= 1'b1;
          payIdx_q  <= 8'h00;
        end else if (chunkEvt) begin
          payPend_q <= 1'b1;
          payIdx_q  <= chunk_q + 8'h01;
        end else if (grantPay[s]) begin
          payPend_q <= 1'b0;
        end
      end
    end

    // boundary strobe to the spreader
    always_ff @(posedge clk_sys) begin
      if (rst) bnd_q <= 1'b0;
      else bnd_q <= bndEvt;
    end

    // a lead difference of 8 or 16 is flagged only; the schedule stays exact
    assign diff = (lead_q[G].hdrLead > lead_q[G].payLead) ?
                  lead_q[G].hdrLead - lead_q[G].payLead :
                  lead_q[G].payLead - lead_q[G].hdrLead;
    assign hazV[s] = fetching & spr_q[s].sensitive
                   & (diff == `SIFS_HAZ_DIFF_A || diff == `SIFS_HAZ_DIFF_B);

    assign hdrPendV[s]    = hdrPend_q;
    assign payPendV[s]    = payPend_q;
    assign payIdxV[s]     = payIdx_q;
    assign fetchV[s]      = fetching;
    assign periodStart[s] = bnd_q;
    assign ovrV[s] = (hdrEvt & hdrPend_q & ~grantHdr[s])
                   | ((firstEvt | chunkEvt) & payPend_q & ~grantPay[s]);
  end

  // ------------------------------------------------------------
  // arbiter: headers first, then lowest spreader index
  // ------------------------------------------------------------
  always_comb begin
    pick      = 2'h0;
    pickHdr   = 1'b0;
    pushValid = 1'b0;
    for (int i = `SIFS_NUM_SPR - 1; i >= 0; i--) begin
      if (payPendV[i]) begin
        pick      = 2'(i);
        pushValid = 1'b1;
      end
    end
    for (int i = `SIFS_NUM_SPR - 1; i >= 0; i--) begin
      if (hdrPendV[i]) begin
        pick      = 2'(i);
        pickHdr   = 1'b1;
        pushValid = 1'b1;
      end
    end
  end

  assign pushData.spreader = pick;
  assign pushData.isHeader = pickHdr;
  assign pushData.chunk    = pickHdr ? 8'h00 : payIdxV[pick];

  // grants only when the fifo accepts, so a full fifo leaves requests pending while the schedulers keep counting
  always_comb begin
    grantHdr = '0;
    grantPay = '0;
    if (pushValid && pushReady) begin
      grantHdr[pick] = pickHdr;
      grantPay[pick] = ~pickHdr;
    end
  end

  // ------------------------------------------------------------
  // request fifo toward the memory system
  // ------------------------------------------------------------
  sifs_fifo #(
    .WIDTH ($bits(sifs_fetch_s)),
    .DEPTH (`SIFS_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .inData   (pushData),
    .outValid (fetchValid),
    .outReady (fetchReady),
    .outData  (fetchReq),
    .level    (fifoLevel)
  );

endmodule : sifs_scheduler

//--- testbench/sifs_scheduler_sva.sv
`timescale 1ns/1ps
`include "sifs_map.svh"
module sifs_scheduler_sva
  import sifs_pkg::*;
(
  input wire logic                     clk_sys,
  input wire logic                     rst,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire logic                     fetchValid,
  input wire logic                     fetchReady,
  input wire sifs_fetch_s              fetchReq,
  input wire logic [`SIFS_NUM_SPR-1:0] periodStart
);
  // ----------------------------------------
  // shadow of configuration seen on the bus
  // ----------------------------------------
  sifs_chan_e sprType_q [4];
  logic       ctrlEn_q;
  wire        apbWr    = psel && penable && pwrite;
  wire        unmapped = (paddr > `SIFS_ADDR_REQCNT) || (paddr[1:0] != 2'h0);

  // only completed writes count, so a refused access never moves the shadow
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) sprType_q[i] <= CH_STATIC;
      ctrlEn_q <= 1'b0;
    end else if (apbWr && !unmapped) begin
      if (paddr == `SIFS_ADDR_CTRL) ctrlEn_q <= pwdata[0];
      if (paddr[7:4] == 4'h1) sprType_q[paddr[3:2]] <= sifs_chan_e'(pwdata[1:0]);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_apb_ready;
    s_setup ##1 s_access |-> pready;
  endproperty
  property p_unmapped_err;
    s_access and unmapped |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  property p_mapped_ok;
    psel && penable && !unmapped |-> !pslverr;
  endproperty
  property p_hold_req;
    fetchValid && !fetchReady |=> fetchValid && $stable(fetchReq);
  endproperty
  property p_start_pulse;
    periodStart != '0 |=> (periodStart & $past(periodStart)) == '0;
  endproperty
  property p_static_quiet;
    fetchValid |-> sprType_q[fetchReq.spreader] != CH_STATIC;
  endproperty
  property p_run_only;
    periodStart != '0 |-> ctrlEn_q || $past(ctrlEn_q);
  endproperty
  property p_reset_quiet;
    disable iff (1'b0) rst |=> !fetchValid && periodStart == '0;
  endproperty

  a_apb_ready: assert property (p_apb_ready) else $error("access phase not answered");
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");
  a_mapped_ok: assert property (p_mapped_ok) else $error("mapped access refused");
  a_hold_req: assert property (p_hold_req) else $error("request changed while stalled");
  a_start_pulse: assert property (p_start_pulse) else $error("boundary pulse too long");
  a_static_quiet: assert property (p_static_quiet) else $error("static spreader fetched");
  a_run_only: assert property (p_run_only) else $error("boundary while stopped");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
endmodule : sifs_scheduler_sva

bind sifs_scheduler sifs_scheduler_sva u_sva (.clk_sys, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .fetchValid, .fetchReady, .fetchReq,
  .periodStart);

//--- testbench/sifs_mem_model.sv
`timescale 1ns/1ps
module sifs_mem_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [1:0] mode,
  input  wire logic       fetchValid,
  output logic            fetchReady
);
  logic phase_q;

  // mode 0 serves at once, 1 every other offer, 2 stalls so the queue backs up
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_q    <= 1'b0;
      fetchReady <= 1'b0;
    end else begin
      phase_q    <= phase_q ^ fetchValid;
      fetchReady <= (mode == 2'h0) || (mode == 2'h1 && phase_q);
    end
  end
endmodule : sifs_mem_model

//--- testbench/test_spreader_input_fetch_scheduler.sv
`timescale 1ns/1ps
`include "sifs_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module test_spreader_input_fetch_scheduler;
  import sifs_pkg::*;
  localparam int IC      = 4;
  localparam int PER [4] = '{64, 0, 96, 80};
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, fetchValid, fetchReady;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  periodStart;
  logic [1:0]  mode;
  logic        err;
  sifs_fetch_s fetchReq;
  int          n_errors, n_compared, cyc, seed, pl, hl;
  int          hdrT [4], c0T [4], prevT [4], expChunk [4], nPop [4], nStart [4];
  int          hdrL [4], payL [4];
  bit          hdrSeen [4];
  bit          timeOn, modelOn;

  sifs_scheduler #(.SLOT_ITERS(64), .FRAME_ITERS(96), .SUBFRAME_ITERS(80), .ITER_CYCLES(IC))
    dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
         .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
         .pslverr(pslverr), .fetchValid(fetchValid), .fetchReady(fetchReady),
         .fetchReq(fetchReq), .periodStart(periodStart));
  sifs_mem_model u_mem (.clk_sys(clk_sys), .rst(rst), .mode(mode),
                        .fetchValid(fetchValid), .fetchReady(fetchReady));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // one APB transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // reference model: order per spreader, chunk numbering, lead and period timing;
  // sampled on the falling edge so design outputs are settled, not racing the flops
  always @(negedge clk_sys) begin
    int s;
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      summarize();
    end
    if (modelOn && fetchValid && fetchReady) begin
      s = fetchReq.spreader;
      nPop[s]++;
      if (fetchReq.isHeader) begin
        hdrSeen[s] = 1;
        hdrT[s] = cyc;
      end else if (fetchReq.chunk == 8'h00) begin
        `CHK("header first", 1'b1, hdrSeen[s])
        hdrSeen[s] = 0;
        c0T[s] = cyc;
        expChunk[s] = 1;
      end else begin
        `CHK("chunk index", expChunk[s][7:0], fetchReq.chunk)
        expChunk[s]++;
      end
    end
    for (int i = 0; i < 4; i++) if (modelOn && PER[i] != 0 && periodStart[i] === 1'b1) begin
      if (timeOn && prevT[i] != 0) begin
        `CHK("period", PER[i] * IC, cyc - prevT[i])
        `CHK("header lead", hdrL[i], (cyc - hdrT[i] + 3) / IC)
        `CHK("payload lead", payL[i], (cyc - c0T[i] + 3) / IC)
      end
      prevT[i] = cyc;
      nStart[i]++;
    end
  end

  initial begin
    seed = 32'h1D27;
    {rst, psel, penable, pwrite, paddr, pwdata, mode} = {1'b1, 3'h0, 8'h00, 32'h0, 2'h0};
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    // reset values, then two refused accesses, a write and a read
    for (int a = 0; a <= 8'h20; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    `CHK("unmapped write err", 1'b1, err)
    apb(1'b0, 8'h26, 32'h0);
    `CHK("unmapped read data", 32'h0, rd)
    // random leads for group 1 keep their difference below 8
    pl = 2 + ($unsigned($random(seed)) % 6);
    hl = pl + 1 + ($unsigned($random(seed)) % 6);
    hdrL = '{9, 9, hl, hl};
    payL = '{1, 1, pl, pl};
    apb(1'b1, `SIFS_ADDR_GRP0, {16'h0, 8'h01, 8'h09});
    apb(1'b1, 8'h0C, {16'h0, pl[7:0], hl[7:0]});
    apb(1'b0, 8'h0C, 32'h0);
    `CHK("group lead readback", {16'h0, pl[7:0], hl[7:0]}, rd)
    apb(1'b1, 8'h10, 32'hD);
    apb(1'b1, 8'h14, 32'h8);
    apb(1'b1, 8'h18, 32'hA);
    apb(1'b1, 8'h1C, 32'hB);
    apb(1'b1, `SIFS_ADDR_CTRL, 32'h1);
    modelOn = 1;
    timeOn = 1;
    repeat (2000) @(posedge clk_sys);
    apb(1'b0, `SIFS_ADDR_STAT, 32'h0);
    `CHK("hazard flags", 4'h1, rd[7:4])
    `CHK("fetching flags", 4'hD, rd[11:8])
    timeOn = 0;
    mode <= 2'h1;
    repeat (1200) @(posedge clk_sys);
    // stall until the queue refuses, then stop and drain it
    modelOn = 0;
    mode <= 2'h2;
    for (int k = 0; k < 1000 && rd[15:12] != 4'h8; k++) apb(1'b0, `SIFS_ADDR_STAT, 32'h0);
    `CHK("queue full", 4'h8, rd[15:12])
    apb(1'b1, `SIFS_ADDR_CTRL, 32'h0);
    mode <= 2'h0;
    for (int k = 0; k < 200 && fetchValid !== 1'b0; k++) @(posedge clk_sys);
    apb(1'b1, `SIFS_ADDR_STAT, 32'h1);
    apb(1'b0, `SIFS_ADDR_STAT, 32'h0);
    `CHK("queue empty", 4'h0, rd[15:12])
    `CHK("overrun cleared", 1'b0, rd[0])
    `CHK("static pops", 0, nPop[1])
    `CHK("boundaries seen", 1'b1, nStart[0] > 8 && nStart[2] > 4 && nStart[3] > 4)
    summarize();
  end
endmodule : test_spreader_input_fetch_scheduler
